// *** hdl/external_pin_interrupts.sv ***
// top of the external pin interrupt block with its apb register file
// What this block does
// - pin activity requests interrupts even when the pin is driven as output
// - three change groups, each requesting on any masked member pin toggle
// - pin change detection keeps working while the clock is stopped
// - enabled low-level line keeps requesting while the pin stays low
// - edges on dedicated lines recognised only while the i/o clock runs
// - low level detected asynchronously so it can wake the part
// - level gone before start-up ends: wake completes, no level interrupt
// - unused upper bits of sense control and mask read as zero
// - a line interrupt needs both global enable and its mask bit
// - the pin is sampled and edges found from the sampled value
// - pulses longer than one clock period produce an interrupt while the i/o clock runs
// - line one sense at bits 3..2: low, change, falling, rising
// - line zero sense at bits 1..0: low, change, falling, rising
// - line flag set on edge, cleared on acknowledge or writing one
// - line flag held cleared while that line uses level sensing
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module external_pin_interrupts
    import pin_irq_pkg::*;
(
    input wire logic SYS_CLK, // system clock, 100 MHz
    input wire logic RST, // synchronous reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic [1:0] EXT_LINE_PINS, // dedicated line pins, bit 1 is line one
    input wire logic [23:0] CHANGE_PINS, // pin change inputs, groups of eight
    input wire logic GLOBAL_IRQ_ENABLE, // core global interrupt flag
    input wire logic IO_CLK_RUN, // i/o clock running (not in deep sleep)
    input wire logic STARTUP_DONE, // wake-up start-up period has ended
    input wire logic [1:0] LINE_ACK, // core entered a line's routine, pulse
    input wire logic [2:0] CHANGE_ACK, // core entered a group's routine, pulse
    output logic [1:0] LINE_REQ, // line requests to the core
    output logic [2:0] CHANGE_GROUP_REQ, // change group requests to the core
    output logic WAKE_REQ // asynchronous wake request
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0] sense_control_reg;
    logic [1:0] pin_interrupt_mask_reg;
    logic [2:0] change_enable_reg;
    logic [2:0] change_flag_reg;
    logic [7:0] change_mask_reg [GROUPS];
    logic [1:0] line_sync;
    logic [23:0] change_sync;
    logic [23:0] change_prev_reg;
    logic [1:0] line_flag;
    logic [1:0] level_req;
    logic [1:0] line_clear;
    logic [2:0] group_hit;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] rd_data_next;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction : addr_is

    function automatic sense_t sense_of(input logic [3:0] ctl, input int lsb);
        return sense_t'(ctl[lsb +: SENSE_W]);
    endfunction : sense_of

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    pin_sync2 #(
        .WIDTH(LINES)
    ) u_line_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .d_in(EXT_LINE_PINS),
        .q_out(line_sync)
    );

    pin_sync2 #(
        .WIDTH(GROUPS * GROUP_W)
    ) u_change_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .d_in(CHANGE_PINS),
        .q_out(change_sync)
    );

    // ------------------------------------------------------------
    // apb slave: zero wait states
    // ------------------------------------------------------------
    assign PREADY = 1'b1;
    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & PENABLE & ~PWRITE;

    always_comb
    begin
        addr_ok = 1'b1;
        rd_data_next = 32'h0000_0000;
        case (PADDR)
            SENSE_CONTROL_ADDR: rd_data_next[3:0] = sense_control_reg;
            PIN_MASK_ADDR: rd_data_next[1:0] = pin_interrupt_mask_reg;
            LINE_FLAG_ADDR: rd_data_next[1:0] = line_flag;
            CHANGE_ENABLE_ADDR: rd_data_next[2:0] = change_enable_reg;
            CHANGE_FLAG_ADDR: rd_data_next[2:0] = change_flag_reg;
            CHANGE_MASK0_ADDR: rd_data_next[7:0] = change_mask_reg[0];
            CHANGE_MASK1_ADDR: rd_data_next[7:0] = change_mask_reg[1];
            CHANGE_MASK2_ADDR: rd_data_next[7:0] = change_mask_reg[2];
            CPU_STATUS_ADDR: rd_data_next[1:0] = line_sync;
            LEVEL_STATUS_ADDR: rd_data_next[1:0] = level_req;
            default: addr_ok = 1'b0;
        endcase
    end

    // read data comes straight from the register file during the access phase
    assign PRDATA = rd_en ? rd_data_next : 32'h0000_0000;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            sense_control_reg <= SENSE_CONTROL_RESET;
        else if (wr_en && addr_is(PADDR, SENSE_CONTROL_ADDR))
            sense_control_reg <= PWDATA[3:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            pin_interrupt_mask_reg <= PIN_MASK_RESET;
        else if (wr_en && addr_is(PADDR, PIN_MASK_ADDR))
            pin_interrupt_mask_reg <= PWDATA[1:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            change_enable_reg <= 3'h0;
        else if (wr_en && addr_is(PADDR, CHANGE_ENABLE_ADDR))
            change_enable_reg <= PWDATA[2:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            change_mask_reg[0] <= CHANGE_MASK_RESET;
            change_mask_reg[1] <= CHANGE_MASK_RESET;
            change_mask_reg[2] <= CHANGE_MASK_RESET;
        end
        else if (wr_en)
        begin
            if (addr_is(PADDR, CHANGE_MASK0_ADDR))
                change_mask_reg[0] <= PWDATA[7:0];
            if (addr_is(PADDR, CHANGE_MASK1_ADDR))
                change_mask_reg[1] <= PWDATA[7:0] & CHANGE_MASK1_USED;
            if (addr_is(PADDR, CHANGE_MASK2_ADDR))
                change_mask_reg[2] <= PWDATA[7:0];
        end
    end

    // ------------------------------------------------------------
    // dedicated lines
    // ------------------------------------------------------------
    assign line_clear = ((wr_en && addr_is(PADDR, LINE_FLAG_ADDR)) ? PWDATA[1:0] : 2'b00) | LINE_ACK;

    line_detect u_line_zero (
        .clk(SYS_CLK),
        .rst(RST),
        .pin_sync(line_sync[0]),
        .io_clk_run(IO_CLK_RUN),
        .sense(sense_of(sense_control_reg, LINE_ZERO_SENSE_LSB)),
        .flag_clear(line_clear[0]),
        .level_req(level_req[0]),
        .flag(line_flag[0])
    );

    line_detect u_line_one (
        .clk(SYS_CLK),
        .rst(RST),
        .pin_sync(line_sync[1]),
        .io_clk_run(IO_CLK_RUN),
        .sense(sense_of(sense_control_reg, LINE_ONE_SENSE_LSB)),
        .flag_clear(line_clear[1]),
        .level_req(level_req[1]),
        .flag(line_flag[1])
    );

    // level request is only taken once start-up is over and the level still holds
    assign LINE_REQ = (line_flag | (level_req & {LINES{STARTUP_DONE}}))
        & pin_interrupt_mask_reg & {LINES{GLOBAL_IRQ_ENABLE}};

    // ------------------------------------------------------------
    // change groups
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            change_prev_reg <= '1; // match the synchroniser preset so reset leaves no false toggle
        else
            change_prev_reg <= change_sync;
    end

    always_comb
    begin
        for (int g = 0; g < GROUPS; g++)
            group_hit[g] = |((change_sync[g*GROUP_W +: GROUP_W] ^ change_prev_reg[g*GROUP_W +: GROUP_W])
                & change_mask_reg[g]);
    end

    // set wins over the clear
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            change_flag_reg <= 3'h0;
        else
            change_flag_reg <= group_hit
                | (change_flag_reg & ~(CHANGE_ACK
                | ((wr_en && addr_is(PADDR, CHANGE_FLAG_ADDR)) ? PWDATA[2:0] : 3'h0)));
    end

    assign CHANGE_GROUP_REQ = change_flag_reg & change_enable_reg & {GROUPS{GLOBAL_IRQ_ENABLE}};

    // ------------------------------------------------------------
    // wake request, purely combinational on raw pins so no clock is needed
    // ------------------------------------------------------------
    always_comb
    begin
        WAKE_REQ = 1'b0;
        for (int l = 0; l < LINES; l++)
            if (sense_of(sense_control_reg, l * SENSE_W) == SENSE_LOW_LEVEL)
                WAKE_REQ = WAKE_REQ | (~EXT_LINE_PINS[l] & pin_interrupt_mask_reg[l]);
        for (int g = 0; g < GROUPS; g++)
            WAKE_REQ = WAKE_REQ | (change_enable_reg[g]
                & |((CHANGE_PINS[g*GROUP_W +: GROUP_W] ^ change_prev_reg[g*GROUP_W +: GROUP_W])
                & change_mask_reg[g]));
    end

endmodule : external_pin_interrupts

// *** hdl/line_detect.sv ***
// sense decoder and request flag for one dedicated interrupt line
`timescale 1ns/1ns
module line_detect
    import pin_irq_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic pin_sync, // synchronised pin level
    input wire logic io_clk_run, // i/o clock running
    input pin_irq_pkg::sense_t sense, // sense selection
    input wire logic flag_clear, // clear pulse from software or acknowledge
    output logic level_req, // low level present
    output logic flag // sticky edge request flag
);
    logic prev_reg;
    logic edge_hit;

    always_ff @(posedge clk)
    begin
        if (rst)
            prev_reg <= 1'b1;
        else
            prev_reg <= pin_sync;
    end

    // edges come from the sampled level only
    always_comb
    begin
        edge_hit = 1'b0;
        unique case (sense)
            SENSE_LOW_LEVEL: edge_hit = 1'b0;
            SENSE_ANY_CHANGE: edge_hit = pin_sync ^ prev_reg;
            SENSE_FALLING: edge_hit = prev_reg & ~pin_sync;
            SENSE_RISING: edge_hit = ~prev_reg & pin_sync;
        endcase
        edge_hit = edge_hit & io_clk_run;
    end

    assign level_req = (sense == SENSE_LOW_LEVEL) & ~pin_sync;

    // set wins over clear; level mode keeps the flag at zero
    always_ff @(posedge clk)
    begin
        if (rst)
            flag <= 1'b0;
        else if (sense == SENSE_LOW_LEVEL)
            flag <= 1'b0;
        else if (edge_hit)
            flag <= 1'b1;
        else if (flag_clear)
            flag <= 1'b0;
    end
endmodule : line_detect

// *** hdl/pin_irq_pkg.sv ***
// constants, register map and sense encodings for the external pin interrupt block
package pin_irq_pkg;

    // ------------------------------------------------------------
    // register byte addresses (apb, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] SENSE_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] PIN_MASK_ADDR = 8'h04;
    localparam logic [7:0] LINE_FLAG_ADDR = 8'h08;
    localparam logic [7:0] CHANGE_ENABLE_ADDR = 8'h0C;
    localparam logic [7:0] CHANGE_FLAG_ADDR = 8'h10;
    localparam logic [7:0] CHANGE_MASK0_ADDR = 8'h14;
    localparam logic [7:0] CHANGE_MASK1_ADDR = 8'h18;
    localparam logic [7:0] CHANGE_MASK2_ADDR = 8'h1C;
    localparam logic [7:0] CPU_STATUS_ADDR = 8'h20;
    localparam logic [7:0] LEVEL_STATUS_ADDR = 8'h24;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int LINE_ZERO_SENSE_LSB = 0;
    localparam int LINE_ONE_SENSE_LSB = 2;
    localparam int SENSE_W = 2;
    localparam int LINES = 2;
    localparam int GROUPS = 3;
    localparam int GROUP_W = 8;
    localparam logic [3:0] SENSE_CONTROL_RESET = 4'h0;
    localparam logic [1:0] PIN_MASK_RESET = 2'h0;
    localparam logic [7:0] CHANGE_MASK_RESET = 8'h00;
    // group one has only seven member pins; bit 7 is unused
    localparam logic [7:0] CHANGE_MASK1_USED = 8'h7F;

    // ------------------------------------------------------------
    // sense selection
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SENSE_LOW_LEVEL = 2'b00,
        SENSE_ANY_CHANGE = 2'b01,
        SENSE_FALLING = 2'b10,
        SENSE_RISING = 2'b11
    } sense_t;

endpackage : pin_irq_pkg

// *** hdl/pin_sync2.sv ***
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [WIDTH-1:0] d_in, // asynchronous input
    output logic [WIDTH-1:0] q_out // synchronised output
);
    logic [WIDTH-1:0] meta_reg;

    initial
    begin
        if (WIDTH < 1)
            $error("pin_sync2: WIDTH must be at least 1");
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '1;
            q_out <= '1;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule : pin_sync2

// *** tb/external_pin_interrupts_tb_top.sv ***
// self-checking bench for the external pin interrupt block
`timescale 1ns/1ns
module external_pin_interrupts_tb_top;
    import pin_irq_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic glb = 1'b0, io_run = 1'b1, st_done = 1'b1, pready, pslverr, wake, errv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [1:0] line_ack = 2'h0, line_set = 2'h3, line_pins, line_req;
    logic [23:0] change_set = 24'hFFFFFF, change_pins;
    logic [2:0] group_req, change_ack = 3'h0;
    int mismatches = 0;
    int num_checks = 0;
    always #5 sys_clk = ~sys_clk;
    pin_source i_pin_source (.clk(sys_clk), .line_set(line_set), .change_set(change_set),
        .line_pins(line_pins), .change_pins(change_pins));
    external_pin_interrupts i_external_pin_interrupts (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_LINE_PINS(line_pins), .CHANGE_PINS(change_pins),
        .GLOBAL_IRQ_ENABLE(glb), .IO_CLK_RUN(io_run), .STARTUP_DONE(st_done), .LINE_ACK(line_ack),
        .CHANGE_ACK(change_ack), .LINE_REQ(line_req), .CHANGE_GROUP_REQ(group_req), .WAKE_REQ(wake));
    // ------------------------------------------------------------
    // apb master, compares and closing
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n == 16)
            mismatches++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_req(input logic got, input logic exp);
        chk_data({31'h0, got}, {31'h0, exp});
    endtask : chk_req
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk_data(rdv, exp);
    endtask : rd_chk
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // fall then rise on one line; flag cleared once by acknowledge, once by writing one
    task automatic run_line(input int n, input logic [1:0] m);
        apb(1'b1, SENSE_CONTROL_ADDR, 32'(m) << (2 * n));
        apb(1'b1, LINE_FLAG_ADDR, 32'h3);
        line_set[n] <= 1'b0;
        tick(6);
        chk_req(line_req[n], m != SENSE_RISING);
        line_ack[n] <= 1'b1;
        tick(1);
        line_ack <= 2'h0;
        tick(1);
        chk_req(line_req[n], 1'b0);
        line_set[n] <= 1'b1;
        tick(6);
        chk_req(line_req[n], m != SENSE_FALLING);
        apb(1'b1, LINE_FLAG_ADDR, 32'h1 << n);
        tick(1);
        chk_req(line_req[n], 1'b0);
    endtask : run_line
    initial
    begin
        tick(2);
        rst <= 1'b0;
        rd_chk(SENSE_CONTROL_ADDR, 32'h0);
        rd_chk(PIN_MASK_ADDR, 32'h0);
        apb(1'b1, SENSE_CONTROL_ADDR, 32'hFFFFFFFF);
        apb(1'b1, PIN_MASK_ADDR, 32'hFFFFFFFF);
        rd_chk(SENSE_CONTROL_ADDR, 32'hF);
        rd_chk(PIN_MASK_ADDR, 32'h3);
        apb(1'b0, 8'h40, 32'h0);
        chk_req(errv, 1'b1);
        chk_req(pready, 1'b1);
        chk_data(rdv, 32'h0);
        glb <= 1'b1;
        for (int n = 0; n < 2; n++)
            for (int m = 1; m < 4; m++)
                run_line(n, m[1:0]);
        apb(1'b1, SENSE_CONTROL_ADDR, 32'h0);
        line_set[0] <= 1'b0;
        tick(6);
        chk_req(line_req[0], 1'b1);
        chk_req(wake, 1'b1);
        rd_chk(LINE_FLAG_ADDR, 32'h0);
        st_done <= 1'b0;
        tick(2);
        chk_req(line_req[0], 1'b0);
        st_done <= 1'b1;
        glb <= 1'b0;
        tick(2);
        chk_req(line_req[0], 1'b0);
        glb <= 1'b1;
        apb(1'b1, PIN_MASK_ADDR, 32'h2);
        tick(1);
        chk_req(line_req[0], 1'b0);
        apb(1'b1, PIN_MASK_ADDR, 32'h3);
        tick(1);
        chk_req(line_req[0], 1'b1);
        line_set[0] <= 1'b1;
        apb(1'b1, SENSE_CONTROL_ADDR, 32'hC);
        apb(1'b1, LINE_FLAG_ADDR, 32'h3);
        io_run <= 1'b0;
        line_set[1] <= 1'b0;
        tick(6);
        line_set[1] <= 1'b1;
        tick(6);
        io_run <= 1'b1;
        tick(4);
        chk_req(line_req[1], 1'b0);
        apb(1'b1, CHANGE_ENABLE_ADDR, 32'h7);
        apb(1'b1, CHANGE_MASK0_ADDR, 32'h1);
        apb(1'b1, CHANGE_MASK1_ADDR, 32'hFF);
        apb(1'b1, CHANGE_MASK2_ADDR, 32'h1);
        rd_chk(CHANGE_MASK1_ADDR, 32'h7F);
        // clock stopped: group changes must still be caught
        io_run <= 1'b0;
        for (int g = 0; g < 3; g++)
        begin
            apb(1'b1, CHANGE_FLAG_ADDR, 32'h7);
            change_set[8 * g + 7] <= 1'b0;
            tick(6);
            chk_req(group_req[g], 1'b0);
            change_set[8 * g] <= 1'b0;
            tick(6);
            chk_req(group_req[g], 1'b1);
            change_ack[g] <= 1'b1;
            tick(1);
            change_ack <= 3'h0;
            tick(1);
            chk_req(group_req[g], 1'b0);
        end
        apb(1'b1, CHANGE_FLAG_ADDR, 32'h7);
        tick(1);
        chk_data({29'h0, group_req}, 32'h0);
        io_run <= 1'b1;
        stop_test();
    end
    initial
    begin
        #100000;
        mismatches++;
        stop_test();
    end
endmodule : external_pin_interrupts_tb_top
bind external_pin_interrupts pin_irq_sva i_pin_irq_sva (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .EXT_LINE_PINS(EXT_LINE_PINS), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IO_CLK_RUN(IO_CLK_RUN),
    .STARTUP_DONE(STARTUP_DONE), .LINE_ACK(LINE_ACK), .LINE_REQ(LINE_REQ));

// *** tb/pin_irq_sva.sv ***
// port-level assertions for the external pin interrupt block
`timescale 1ns/1ns
module pin_irq_sva
    import pin_irq_pkg::*;
(
    input wire logic SYS_CLK, // clock
    input wire logic RST, // sync reset
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access
    input wire logic PWRITE, // apb direction
    input wire logic [7:0] PADDR, // apb address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [31:0] PRDATA, // apb read data
    input wire logic [1:0] EXT_LINE_PINS, // line pins
    input wire logic GLOBAL_IRQ_ENABLE, // global enable
    input wire logic IO_CLK_RUN, // i/o clock running
    input wire logic STARTUP_DONE, // start-up over
    input wire logic [1:0] LINE_ACK, // acknowledge pulses
    input wire logic [1:0] LINE_REQ // line requests
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    logic [3:0] sense_reg;
    logic [1:0] mask_reg;
    logic wr, rd, lvl0, en1, en0;
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign lvl0 = !EXT_LINE_PINS[0] && sense_reg[1:0] == 2'b00 && mask_reg[0] && GLOBAL_IRQ_ENABLE && STARTUP_DONE;
    assign en1 = IO_CLK_RUN && sense_reg[3:2] == 2'b11 && mask_reg[1] && GLOBAL_IRQ_ENABLE && !LINE_ACK[1];
    assign en0 = IO_CLK_RUN && sense_reg[1:0] == 2'b10 && mask_reg[0] && GLOBAL_IRQ_ENABLE && !LINE_ACK[0];
    // ------------------------------------------------------------
    // shadow of sense and mask, so checks know what was programmed
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            sense_reg <= SENSE_CONTROL_RESET;
            mask_reg <= PIN_MASK_RESET;
        end
        else if (wr && PADDR == SENSE_CONTROL_ADDR)
            sense_reg <= PWDATA[3:0];
        else if (wr && PADDR == PIN_MASK_ADDR)
            mask_reg <= PWDATA[1:0];
    end
    irq_gate_a: assert property (!GLOBAL_IRQ_ENABLE |-> LINE_REQ == 2'b00)
        else $error("line request while global enable is low");
    mask_gate_a: assert property (!mask_reg[1] |-> !LINE_REQ[1])
        else $error("line one request while masked");
    sense_read_a: assert property (rd && PADDR == SENSE_CONTROL_ADDR |-> PRDATA == {28'h0, sense_reg})
        else $error("sense control read back wrong");
    mask_read_a: assert property (rd && PADDR == PIN_MASK_ADDR |-> PRDATA == {30'h0, mask_reg})
        else $error("mask read back wrong");
    level_hold_a: assert property (lvl0 [*3] |-> LINE_REQ[0])
        else $error("held low level not requesting");
    level_start_a: assert property (!STARTUP_DONE && sense_reg[1:0] == 2'b00 |-> !LINE_REQ[0])
        else $error("level request before start-up ended");
    rise_one_a: assert property (($rose(EXT_LINE_PINS[1]) && en1) ##1 (EXT_LINE_PINS[1] && en1) [*2]
        |-> ##[0:3] LINE_REQ[1]) else $error("line one rising edge missed");
    fall_zero_a: assert property (($fell(EXT_LINE_PINS[0]) && en0) ##1 (!EXT_LINE_PINS[0] && en0) [*2]
        |-> ##[0:3] LINE_REQ[0]) else $error("line zero falling edge missed");
    cover property (lvl0 [*3]);
    cover property ($rose(LINE_REQ[1]));
    cover property (rd && PADDR == PIN_MASK_ADDR);
endmodule : pin_irq_sva

// *** tb/pin_source.sv ***
// stand-in for the outside sources that drive the interrupt pins
`timescale 1ns/1ns
module pin_source
(
    input wire logic clk, // bench clock
    input wire logic [1:0] line_set, // wanted line levels
    input wire logic [23:0] change_set, // wanted change pin levels
    output logic [1:0] line_pins, // driven line pins
    output logic [23:0] change_pins // driven change pins
);
    // ------------------------------------------------------------
    // levels stay until told otherwise, so a waking low outlasts start-up
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        line_pins <= line_set;
        change_pins <= change_set;
    end
endmodule : pin_source
